// ### radio_ctrl_pkg.sv
// constants for the radio mode control register block
// assumes one 20 MHz core clock and a simple byte-wide register port
package radio_ctrl_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned SETTLE_STEP_NS = 2000;
   localparam int unsigned STEP_CYCLES = (SETTLE_STEP_NS * (CLK_HZ / 1000000)) / 1000;
   localparam logic [5:0] ADDR_MODE_CONTROL = 6'h03;
   localparam logic [5:0] ADDR_CODE_WIDTH = 6'h04;
   localparam logic [5:0] ADDR_LOCK_COUNT = 6'h38;
   localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
   localparam logic [7:0] CODE_WIDTH_RESET = 8'h00;
   localparam logic [7:0] LOCK_COUNT_RESET = 8'h64;
   localparam int unsigned BIT_RX_ON = 7;
   localparam int unsigned BIT_TX_ON = 6;
   localparam int unsigned BIT_HALF_SELECT = 5;
   localparam int unsigned BIT_LOCK_BYPASS = 4;
   localparam int unsigned BIT_AMP_MANUAL = 3;
   localparam int unsigned BIT_AMP_ON = 2;
   localparam int unsigned BIT_CODE_SHORT = 2;
   localparam logic [7:0] MODE_CONTROL_MASK = 8'hFC;
   localparam logic [7:0] CODE_WIDTH_MASK = 8'h07;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOCK = 2'b01,
      ST_COUNT = 2'b11,
      ST_RUN = 2'b10
   } settle_state_t;
endpackage

// ### step_timer.sv
// step timer: one pulse per settle step of 2 us
// assumes clear from the sequencer restarts the step phase
`timescale 1ns/100ps
module step_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   output logic tick
);
   logic [7:0] count;
   logic [7:0] next_count;
   always_comb begin
      next_count = count + 8'h01;
      if (clear || count == 8'(radio_ctrl_pkg::STEP_CYCLES - 1)) begin
         next_count = 8'h00;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         count <= 8'h00;
      end else begin
         count <= next_count;
      end
   end
   assign tick = !clear && count == 8'(radio_ctrl_pkg::STEP_CYCLES - 1);
endmodule

// ### spread_select.sv
// passes the stored 64-chip code, or with code_short chooses its 32-chip half
// assumes code is stable while the radio runs
`timescale 1ns/100ps
module spread_select (
   input wire logic [63:0] code,
   input wire logic code_short,
   input wire logic half_upper,
   output logic [63:0] code_used
);
   always_comb begin
      if (!code_short) begin
         code_used = code;
      end else if (half_upper) begin
         code_used = {32'h0000_0000, code[63:32]};
      end else begin
         code_used = {32'h0000_0000, code[31:0]};
      end
   end
endmodule

// ### radio_mode_control.sv
// radio mode control register, settle sequencer and amplifier control
// assumes a byte register port from the serial interface, one cycle strobes
`timescale 1ns/100ps
module radio_mode_control (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [5:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WRITE,
   input wire logic REG_READ,
   output logic [7:0] REG_RDATA,
   input wire logic [63:0] SPREAD_CODE,
   input wire logic SYNTH_LOCK,
   input wire logic BASEBAND_AMP_ON,
   output logic SYNTH_ON,
   output logic RX_ACTIVE,
   output logic TX_ACTIVE,
   output logic SETTLING,
   output logic AMP_ENABLE,
   output logic CODE_SHORT,
   output logic [63:0] CODE_USED
);
   logic [7:0] mode_control;
   logic [7:0] code_width;
   logic [7:0] lock_count;
   logic [7:0] next_mode_control;
   logic [7:0] next_code_width;
   logic [7:0] next_lock_count;
   logic [7:0] next_rdata;
   radio_ctrl_pkg::settle_state_t state;
   radio_ctrl_pkg::settle_state_t next_state;
   logic [7:0] settle_left;
   logic [7:0] next_settle_left;
   logic rx_active;
   logic tx_active;
   logic next_rx_active;
   logic next_tx_active;
   logic amp_enable;
   logic next_amp_enable;
   logic [63:0] code_used;
   logic want_rx;
   logic want_tx;
   logic bypass;
   logic tick;
   logic step_clear;

   assign want_rx = mode_control[radio_ctrl_pkg::BIT_RX_ON];
   assign want_tx = mode_control[radio_ctrl_pkg::BIT_TX_ON];
   assign bypass = mode_control[radio_ctrl_pkg::BIT_LOCK_BYPASS];

   // register writes; mode control bits 1:0 kept zero whatever software sends
   always_comb begin
      next_mode_control = mode_control;
      next_code_width = code_width;
      next_lock_count = lock_count;
      if (REG_WRITE) begin
         case (REG_ADDR)
            radio_ctrl_pkg::ADDR_MODE_CONTROL: begin
               next_mode_control = REG_WDATA & radio_ctrl_pkg::MODE_CONTROL_MASK;
            end
            radio_ctrl_pkg::ADDR_CODE_WIDTH: begin
               next_code_width = REG_WDATA & radio_ctrl_pkg::CODE_WIDTH_MASK;
            end
            radio_ctrl_pkg::ADDR_LOCK_COUNT: begin
               next_lock_count = REG_WDATA;
            end
            default: begin
               next_lock_count = lock_count;
            end
         endcase
      end
   end

   // read data registered one cycle after the strobe; unmapped reads zero
   always_comb begin
      next_rdata = 8'h00;
      if (REG_READ) begin
         case (REG_ADDR)
            radio_ctrl_pkg::ADDR_MODE_CONTROL: next_rdata = mode_control;
            radio_ctrl_pkg::ADDR_CODE_WIDTH: next_rdata = code_width;
            radio_ctrl_pkg::ADDR_LOCK_COUNT: next_rdata = lock_count;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         mode_control <= radio_ctrl_pkg::MODE_CONTROL_RESET;
         code_width <= radio_ctrl_pkg::CODE_WIDTH_RESET;
         lock_count <= radio_ctrl_pkg::LOCK_COUNT_RESET;
         REG_RDATA <= 8'h00;
      end else begin
         mode_control <= next_mode_control;
         code_width <= next_code_width;
         lock_count <= next_lock_count;
         REG_RDATA <= next_rdata;
      end
   end

   step_timer u_step (
      .clk(MCLK),
      .rst(SRST),
      .clear(step_clear),
      .tick(tick)
   );

   // settle sequencer; dropping both enables aborts and returns to idle
   always_comb begin
      next_state = state;
      next_settle_left = settle_left;
      step_clear = 1'b1;
      case (state)
         radio_ctrl_pkg::ST_IDLE: begin
            if (want_rx || want_tx) begin
               next_settle_left = lock_count;
               if (bypass) begin
                  next_state = radio_ctrl_pkg::ST_COUNT;
               end else begin
                  next_state = radio_ctrl_pkg::ST_LOCK;
               end
            end
         end
         radio_ctrl_pkg::ST_LOCK: begin
            if (!(want_rx || want_tx)) begin
               next_state = radio_ctrl_pkg::ST_IDLE;
            end else if (SYNTH_LOCK || bypass) begin
               next_state = radio_ctrl_pkg::ST_COUNT;
               next_settle_left = lock_count;
            end
         end
         radio_ctrl_pkg::ST_COUNT: begin
            step_clear = 1'b0;
            if (!(want_rx || want_tx)) begin
               next_state = radio_ctrl_pkg::ST_IDLE;
            end else if (settle_left == 8'h00) begin
               next_state = radio_ctrl_pkg::ST_RUN;
            end else if (tick) begin
               next_settle_left = settle_left - 8'h01;
            end
         end
         radio_ctrl_pkg::ST_RUN: begin
            if (!(want_rx || want_tx)) begin
               next_state = radio_ctrl_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = radio_ctrl_pkg::ST_IDLE;
         end
      endcase
   end

   // mode outputs only after settling; amplifier select
   always_comb begin
      next_rx_active = want_rx && state == radio_ctrl_pkg::ST_RUN;
      next_tx_active = want_tx && state == radio_ctrl_pkg::ST_RUN;
      if (mode_control[radio_ctrl_pkg::BIT_AMP_MANUAL]) begin
         next_amp_enable = mode_control[radio_ctrl_pkg::BIT_AMP_ON];
      end else begin
         next_amp_enable = BASEBAND_AMP_ON;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         state <= radio_ctrl_pkg::ST_IDLE;
         settle_left <= 8'h00;
         rx_active <= 1'b0;
         tx_active <= 1'b0;
         amp_enable <= 1'b0;
      end else begin
         state <= next_state;
         settle_left <= next_settle_left;
         rx_active <= next_rx_active;
         tx_active <= next_tx_active;
         amp_enable <= next_amp_enable;
      end
   end

   spread_select u_spread (
      .code(SPREAD_CODE),
      .code_short(code_width[radio_ctrl_pkg::BIT_CODE_SHORT]),
      .half_upper(mode_control[radio_ctrl_pkg::BIT_HALF_SELECT]),
      .code_used(code_used)
   );

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         CODE_USED <= 64'h0000_0000_0000_0000;
      end else begin
         CODE_USED <= code_used;
      end
   end

   assign SYNTH_ON = state != radio_ctrl_pkg::ST_IDLE;
   assign SETTLING = state == radio_ctrl_pkg::ST_LOCK || state == radio_ctrl_pkg::ST_COUNT;
   assign RX_ACTIVE = rx_active;
   assign TX_ACTIVE = tx_active;
   assign AMP_ENABLE = amp_enable;
   assign CODE_SHORT = code_width[radio_ctrl_pkg::BIT_CODE_SHORT];
endmodule

// ### synth_model.sv
// synthesizer lock source for the settle sequencer
// assumes synth_on from the block powers the synthesizer
`timescale 1ns/100ps
module synth_model #(parameter int DELAY = 100) (
   input wire logic clk,
   input wire logic synth_on,
   output logic lock
);
   int n = 0;
   initial lock = 1'b0;
   // no lock while powered down, so a stale lock cannot shorten the wait
   always @(posedge clk) begin
      n <= synth_on ? n + 1 : 0;
      lock <= synth_on && n >= DELAY;
   end
endmodule

// ### radio_mode_control_props.sv
// checker for the radio mode control block
// assumes one clock domain; shadows mode control and the code width short bit from the write port, not lock count
`timescale 1ns/100ps
module radio_mode_control_props (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [5:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WRITE,
   input wire logic REG_READ,
   input wire logic [7:0] REG_RDATA,
   input wire logic [63:0] SPREAD_CODE,
   input wire logic SYNTH_LOCK,
   input wire logic BASEBAND_AMP_ON,
   input wire logic RX_ACTIVE,
   input wire logic TX_ACTIVE,
   input wire logic SETTLING,
   input wire logic AMP_ENABLE,
   input wire logic CODE_SHORT,
   input wire logic [63:0] CODE_USED
);
   logic [7:0] ctl;
   logic cw;
   logic amp_want;
   logic [63:0] code_want;
   assign amp_want = ctl[3] ? ctl[2] : BASEBAND_AMP_ON;
   assign code_want = cw ? {32'h0, ctl[5] ? SPREAD_CODE[63:32] : SPREAD_CODE[31:0]} : SPREAD_CODE;
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ctl <= 8'h00;
         cw <= 1'b0;
      end else if (REG_WRITE && REG_ADDR == 6'h03) begin
         ctl <= REG_WDATA & 8'hFC;
      end else if (REG_WRITE && REG_ADDR == 6'h04) begin
         cw <= REG_WDATA[2];
      end
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   AST_RX: assert property (RX_ACTIVE |-> $past(ctl[7])) else $error("rx without enable");
   AST_TX: assert property (TX_ACTIVE |-> $past(ctl[6])) else $error("tx without enable");
   AST_AMP: assert property (!$past(SRST) |-> AMP_ENABLE == $past(amp_want))
      else $error("amplifier state wrong");
   AST_CODE: assert property (!$past(SRST) |-> CODE_USED == $past(code_want))
      else $error("code half wrong");
   AST_SHORT: assert property (CODE_SHORT == cw) else $error("code width wrong");
   AST_RD: assert property (REG_READ && !REG_WRITE && REG_ADDR == 6'h03 |=> REG_RDATA == $past(ctl))
      else $error("control readback wrong");
   AST_RD0: assert property (!$past(REG_READ) |-> REG_RDATA == 8'h00) else $error("stale read data");
   AST_LOCK: assert property (SETTLING && (ctl[7] || ctl[6]) && !ctl[4] && !SYNTH_LOCK
      |=> SETTLING) else $error("settle ended without lock");
endmodule
bind radio_mode_control radio_mode_control_props i_radio_mode_control_props (.*);

// ### tb_radio_mode_control.sv
// testbench for the radio mode control register block
// assumes the checker is bound in and synth_model supplies lock
`timescale 1ns/100ps
module tb_radio_mode_control;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [5:0] addr = 6'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [63:0] code = 64'h0123456789ABCDEF;
   logic bb_amp = 1'b0;
   logic lock, synth_on, rx, tx, settling, amp, short_code;
   logic [7:0] rdata;
   logic [63:0] used;
   int n_mismatch = 0;
   int cmp_count = 0;
   int n;
   radio_mode_control i_radio_mode_control (.MCLK(mclk), .SRST(srst), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WRITE(wr_en), .REG_READ(rd_en), .REG_RDATA(rdata),
      .SPREAD_CODE(code), .SYNTH_LOCK(lock), .BASEBAND_AMP_ON(bb_amp), .SYNTH_ON(synth_on),
      .RX_ACTIVE(rx), .TX_ACTIVE(tx), .SETTLING(settling), .AMP_ENABLE(amp),
      .CODE_SHORT(short_code), .CODE_USED(used));
   synth_model i_synth_model (.clk(mclk), .synth_on(synth_on), .lock(lock));
   initial begin
      forever #25 mclk = ~mclk;
   end
   task test_done();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge mclk);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge mclk);
      wr_en = 1'b0;
   endtask
   task rd(input logic [5:0] a, input logic [7:0] e);
      @(negedge mclk);
      addr = a;
      rd_en = 1'b1;
      @(negedge mclk);
      rd_en = 1'b0;
      chk(rdata, e);
   endtask
   // cycles from the enabling write until the mode goes active
   task settle(input logic [7:0] cnt, input logic [7:0] mode, input int lo, input int hi);
      wr(6'h38, cnt);
      wr(6'h03, mode);
      @(negedge mclk);
      n = 1;
      chk({synth_on, settling}, 2'b11);
      while (!(rx || tx) && n < 3000) begin
         @(negedge mclk);
         n++;
      end
      chk(n >= lo && n <= hi, 1'b1);
      if (n >= 3000) test_done();
      chk({rx, tx}, mode[7:6]);
      chk({synth_on, settling}, 2'b10);
      wr(6'h03, 8'h00);
      rd(6'h03, 8'h00);
      chk({rx, tx}, 2'b00);
      chk({synth_on, settling}, 2'b00);
   endtask
   initial begin
      repeat (2) @(negedge mclk);
      srst = 1'b0;
      rd(6'h03, 8'h00);
      rd(6'h04, 8'h00);
      rd(6'h38, 8'h64);
      rd(6'h3F, 8'h00);
      // software keeps bits 1:0 at zero
      for (int i = 0; i < 8; i++) begin
         wr(6'h03, {4'h0, i[1:0], 2'b00});
         bb_amp = i[2];
         rd(6'h03, {4'h0, i[1:0], 2'b00});
         chk(amp, i[1] ? i[0] : i[2]);
      end
      for (int i = 0; i < 4; i++) begin
         wr(6'h04, {5'h00, i[1], 2'b00});
         wr(6'h03, {2'b00, i[0], 5'h00});
         rd(6'h04, {5'h00, i[1], 2'b00});
         chk(used, i[1] ? {32'h0, i[0] ? code[63:32] : code[31:0]} : code);
      end
      settle(8'h01, 8'h90, 40, 48);
      settle(8'h19, 8'h40, 1100, 1115);
      test_done();
   end
endmodule
